// File: hdl/dmc_pkg.sv
/*
 * package for the 4k x 1 dynamic memory controller: pin widths, timing
 * figures in ns and derived cycle counts, request codes.
 * assumes a 125 MHz clock on every module that imports it.
 */
package dmc_pkg;
    // =====================================================================
    // widths
    localparam int ADDR_W     = 12;
    localparam int HALF_W     = 6;
    localparam int ROWS       = 64;
    localparam int ROW_W      = 6;
    // =====================================================================
    // timing figures, ns, and clock rate
    localparam int CLK_PERIOD_NS          = 8;
    localparam int ROW_PRECHARGE_NS       = 120;
    localparam int ROW_PULSE_NS           = 200;
    localparam int ROW_ADDR_HOLD_NS       = 25;
    localparam int ROW_TO_COLUMN_DELAY_NS = 65;  // below the max, so access is row-limited
    localparam int COL_PULSE_NS           = 135;
    localparam int ACCESS_FROM_COLUMN_NS  = 135;
    localparam int COLUMN_TO_WRITE_DELAY_NS = 80;
    localparam int WRITE_PULSE_NS         = 55;
    localparam int COL_PRECHARGE_NS       = 80;
    localparam int REFRESH_PERIOD_NS      = 2000000;
    localparam int POWER_UP_CYCLES        = 8;
    // =====================================================================
    // cycle counts, least times rounded up
    function automatic int cyc_up(input int ns);
        return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction
    localparam int RP_CYC   = cyc_up(ROW_PRECHARGE_NS);
    localparam int RAS_CYC  = cyc_up(ROW_PULSE_NS);
    localparam int RAH_CYC  = cyc_up(ROW_ADDR_HOLD_NS);
    localparam int RCD_CYC  = cyc_up(ROW_TO_COLUMN_DELAY_NS);
    localparam int CAS_CYC  = cyc_up(COL_PULSE_NS);
    localparam int CAC_CYC  = cyc_up(ACCESS_FROM_COLUMN_NS) + 1;
    localparam int CWD_CYC  = cyc_up(COLUMN_TO_WRITE_DELAY_NS);
    localparam int WP_CYC   = cyc_up(WRITE_PULSE_NS);
    localparam int CP_CYC   = cyc_up(COL_PRECHARGE_NS);
    // refresh interval per row, longest time so rounded down
    localparam int REF_ROW_CYC = REFRESH_PERIOD_NS / ROWS / CLK_PERIOD_NS;
    localparam int CNT_W    = 13;
    // =====================================================================
    // request kinds from the user side
    localparam logic [1:0] OP_READ   = 2'h0;
    localparam logic [1:0] OP_WRITE  = 2'h1;  // early write
    localparam logic [1:0] OP_RMW    = 2'h2;  // read then delayed write
    localparam logic [1:0] OP_REFONLY = 2'h3; // row-strobe-only refresh
endpackage

// File: hdl/dmc_timer.sv
/*
 * down counter used to time strobe phases.
 * assumes same clock and reset as the controller.
 */
module dmc_timer (
    input  wire logic                    i_clk,   // system clock
    input  wire logic                    i_rstn,  // async reset, low
    input  wire logic                    i_load,  // load new count
    input  wire logic [dmc_pkg::CNT_W-1:0] i_val, // count to load
    output logic                         o_done   // count reached zero
);
    import dmc_pkg::*;
    logic [CNT_W-1:0] cnt_q, cnt_d;

    // =====================================================================
    // next count
    always_comb begin
        cnt_d = cnt_q;
        if (i_load) begin
            cnt_d = i_val;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // register
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign o_done = (cnt_q == '0);  // no path from i_load, so no loop through the sequencer
endmodule // dmc_timer

// File: hdl/dmc_ctrl.sv
/*
 * host-side controller for a 4096 x 1 dynamic memory: multiplexes the
 * address onto six pins, sequences the row and column strobes, performs
 * read, early write, read-modify-write and row-only refresh, and runs
 * the power-up and periodic refresh on its own.
 * assumes the memory's data output arrives asynchronously on i_dout.
 */
// Functional notes
// R01 - drive 12-bit address as row half then column half on six pins
// R02 - column address and select may be set before column strobe falls
// R03 - device takes data in at the later of write or column strobe fall
// R04 - early write: write low before column strobe, data valid at that edge
// R05 - delayed write: write falls after column strobe, data valid around it
// R06 - select high at column fall makes device ignore the write
// R07 - reads keep write high through the whole column strobe low time
// R08 - device floats output at each column strobe fall
// R09 - selected read cycles drive the stored bit by access time
// R10 - selected early write drives the written bit by access time
// R11 - output holds until next column fall; row-only cycles leave it
// R12 - column strobe without row strobe floats the output
// R13 - deselected full cycle leaves the output floating
// R14 - refresh all 64 rows within each 2 ms
// R15 - any row-strobed cycle refreshes the latched row
// R16 - refresh by write cycle keeps select high
// R17 - long row-only runs may float output; next column cycle restores it
// R18 - refresh with parallel wired outputs keeps column strobe high
// R19 - page mode keeps row strobe low over several column cycles
// R20 - select acts independently in each page cycle
// R21 - at least 8 refreshing cycles after power-up before use
// R22 - write timing picks early write or read-write output data
// R23 - cell index is row half joined with column half
module dmc_ctrl (
    input  wire logic                       i_clk,      // system clock
    input  wire logic                       i_rstn,     // async reset, low
    input  wire logic                       i_req,      // request valid
    input  wire logic [1:0]                 i_op,       // request kind
    input  wire logic [dmc_pkg::ADDR_W-1:0] i_addr,     // cell address
    input  wire logic                       i_wdata,    // bit to write
    input  wire logic                       i_page,     // keep row open after
    input  wire logic                       i_sel_n,    // chip select level to use
    input  wire logic                       i_dout,     // memory data out pin
    output logic                            o_ready,    // request may be taken
    output logic                            o_rvalid,   // read data pulse
    output logic                            o_rdata,    // read data
    output logic                            o_init_done,// power-up refreshes done
    output logic                            o_ras_n,    // row strobe
    output logic                            o_cas_n,    // column strobe
    output logic                            o_we_n,     // write strobe
    output logic                            o_cs_n,     // chip select
    output logic [dmc_pkg::HALF_W-1:0]      o_a,        // address pins
    output logic                            o_din       // memory data in
);
    import dmc_pkg::*;

    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_RAS   = 8'h02,
        ST_RCD   = 8'h04,
        ST_CAS   = 8'h08,
        ST_WR    = 8'h10,
        ST_CP    = 8'h20,
        ST_RP    = 8'h40,
        ST_OPEN  = 8'h80
    } dmc_state_t;

    dmc_state_t           st_q, st_d;
    logic                 ras_n_q, ras_n_d, cas_n_q, cas_n_d, we_n_q, we_n_d;
    logic                 cs_n_q, cs_n_d, din_q, din_d;
    logic [HALF_W-1:0]    a_q, a_d;
    logic [1:0]           op_q, op_d;
    logic [HALF_W-1:0]    row_q, row_d, col_q, col_d;
    logic                 rvalid_q, rvalid_d, rdata_q, rdata_d;
    logic                 ready_q, ready_d;
    logic [3:0]           init_q, init_d;
    logic                 held_q, held_d, init_done_q, init_done_d; // page-miss request waiting, init flag
    logic                 ref_pend_q, ref_pend_d, is_ref_q, is_ref_d;
    logic [ROW_W-1:0]     ref_row_q, ref_row_d;
    logic [CNT_W-1:0]     ref_cnt_q, ref_cnt_d;
    logic                 dout_s1_q, dout_s2_q;
    logic                 t_load, t_done;
    logic [CNT_W-1:0]     t_val;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        return CNT_W'(n - 1);
    endfunction

    dmc_timer u_timer (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_load (t_load),
        .i_val  (t_val),
        .o_done (t_done)
    );

    // =====================================================================
    // data out pin synchroniser
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            dout_s1_q <= 1'b0;
            dout_s2_q <= 1'b0;
        end else begin
            dout_s1_q <= i_dout;
            dout_s2_q <= dout_s1_q;
        end
    end

    // =====================================================================
    // refresh interval counter
    always_comb begin
        ref_cnt_d  = ref_cnt_q;
        ref_pend_d = ref_pend_q;
        if (ref_cnt_q == '0) begin
            ref_cnt_d  = cyc(REF_ROW_CYC);
            ref_pend_d = 1'b1;                           // [R14]
        end else begin
            ref_cnt_d = ref_cnt_q - 1'b1;
        end
        if (st_q == ST_RP && is_ref_q && !(ref_cnt_q == '0)) begin
            ref_pend_d = 1'b0;                           // set wins over clear
        end
    end

    // =====================================================================
    // cycle sequencer
    always_comb begin
        st_d = st_q; ras_n_d = ras_n_q; cas_n_d = cas_n_q; we_n_d = we_n_q;
        cs_n_d = cs_n_q; din_d = din_q; a_d = a_q; op_d = op_q;
        row_d = row_q; col_d = col_q; rvalid_d = 1'b0; rdata_d = rdata_q;
        init_d = init_q; is_ref_d = is_ref_q; ref_row_d = ref_row_q; held_d = held_q;
        t_load = 1'b0; t_val = '0; ready_d = 1'b0;
        unique case (st_q)
            ST_IDLE, ST_OPEN: begin
                if (st_q == ST_IDLE && (ref_pend_q || init_q != 4'(POWER_UP_CYCLES)) && t_done) begin
                    is_ref_d = 1'b1; op_d = OP_REFONLY;
                    a_d = ref_row_q; row_d = ref_row_q;  // [R15]
                    ras_n_d = 1'b0; cs_n_d = 1'b1;       // [R16] [R18]
                    t_load = 1'b1; t_val = cyc(RAS_CYC);
                    st_d = ST_RAS;
                end else if (st_q == ST_OPEN && ref_pend_q) begin
                    ras_n_d = 1'b1; t_load = 1'b1; t_val = cyc(RP_CYC);
                    st_d = ST_RP;                        // close page for refresh
                end else if (i_req && ready_q && t_done) begin
                    is_ref_d = 1'b0; op_d = i_op; din_d = i_wdata;
                    row_d = i_addr[ADDR_W-1:HALF_W];     // [R23]
                    col_d = i_addr[HALF_W-1:0];
                    cs_n_d = i_sel_n;                    // [R20]
                    if (st_q == ST_OPEN && i_addr[ADDR_W-1:HALF_W] == row_q && i_op != OP_REFONLY) begin // [R19]
                        a_d = i_addr[HALF_W-1:0];        // [R02]
                        we_n_d = (i_op != OP_WRITE);     // [R04] [R07]
                        t_load = 1'b1; t_val = cyc(1);
                        st_d = ST_RCD;
                    end else if (st_q == ST_OPEN) begin  // page miss: keep request, close row first
                        ras_n_d = 1'b1; held_d = 1'b1;
                        t_load = 1'b1; t_val = cyc(RP_CYC);
                        st_d = ST_RP;
                    end else begin
                        a_d = i_addr[ADDR_W-1:HALF_W];   // [R01]
                        ras_n_d = 1'b0;
                        t_load = 1'b1; t_val = (i_op == OP_REFONLY) ? cyc(RAS_CYC) : cyc(RAH_CYC);
                        st_d = ST_RAS;
                    end
                end
                ready_d = (st_d == st_q) && !ref_pend_d; // never offered when a refresh would win
            end
            ST_RAS: begin
                if (op_q == OP_REFONLY) begin            // cas stays high [R18]
                    if (t_done) begin
                        ras_n_d = 1'b1;
                        if (init_q != 4'(POWER_UP_CYCLES)) init_d = init_q + 4'h1; // [R21]
                        if (is_ref_q) ref_row_d = ref_row_q + 1'b1; // user row-only cycles keep the sweep
                        t_load = 1'b1; t_val = cyc(RP_CYC);
                        st_d = ST_RP;
                    end
                end else if (t_done) begin
                    a_d = col_q;                         // [R01] [R02]
                    we_n_d = (op_q != OP_WRITE);         // [R04] [R07] [R22]
                    t_load = 1'b1; t_val = cyc(RCD_CYC - RAH_CYC);
                    st_d = ST_RCD;
                end
            end
            ST_RCD: begin
                if (t_done) begin
                    cas_n_d = 1'b0;                      // [R03]
                    t_load = 1'b1;
                    t_val = (op_q == OP_RMW) ? cyc(CWD_CYC) : cyc(CAC_CYC);
                    st_d = ST_CAS;
                end
            end
            ST_CAS: begin
                if (t_done && op_q == OP_RMW && we_n_q) begin
                    we_n_d = 1'b0;                       // delayed write [R05] [R22]
                    t_load = 1'b1; t_val = cyc(CAC_CYC - CWD_CYC);
                    st_d = ST_WR;
                end else if (t_done) begin
                    if (op_q != OP_WRITE && !cs_n_q) begin
                        rvalid_d = 1'b1; rdata_d = dout_s2_q; // [R09]
                    end
                    cas_n_d = 1'b1; we_n_d = 1'b1;
                    t_load = 1'b1; t_val = cyc(CP_CYC);
                    st_d = ST_CP;
                end
            end
            ST_WR: begin
                if (t_done) begin
                    if (!cs_n_q) begin
                        rvalid_d = 1'b1; rdata_d = dout_s2_q; // read-write data [R09]
                    end
                    cas_n_d = 1'b1; we_n_d = 1'b1;
                    t_load = 1'b1; t_val = cyc(CP_CYC);
                    st_d = ST_CP;
                end
            end
            ST_CP: begin
                if (t_done) begin
                    if (i_page) begin
                        st_d = ST_OPEN;                  // [R19]
                        ready_d = !ref_pend_d;
                    end else begin
                        ras_n_d = 1'b1; t_load = 1'b1; t_val = cyc(RP_CYC);
                        st_d = ST_RP;
                    end
                end
            end
            ST_RP: begin
                if (t_done && held_q) begin
                    held_d = 1'b0; a_d = row_q; ras_n_d = 1'b0; // held request opens its row [R01]
                    t_load = 1'b1;
                    t_val = (op_q == OP_REFONLY) ? cyc(RAS_CYC) : cyc(RAH_CYC);
                    st_d = ST_RAS;
                end else if (t_done) begin
                    st_d = ST_IDLE;
                    ready_d = (init_q == 4'(POWER_UP_CYCLES)) && !ref_pend_d;
                end
            end
            default: st_d = ST_IDLE;
        endcase
        init_done_d = (init_d == 4'(POWER_UP_CYCLES)); // [R21]
    end

    // =====================================================================
    // state and pin registers
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_q <= ST_IDLE; ras_n_q <= 1'b1; cas_n_q <= 1'b1; we_n_q <= 1'b1;
            cs_n_q <= 1'b1; din_q <= 1'b0; a_q <= '0; op_q <= OP_READ;
            row_q <= '0; col_q <= '0; rvalid_q <= 1'b0; rdata_q <= 1'b0;
            init_q <= 4'h0; is_ref_q <= 1'b0; ref_row_q <= '0;
            ref_cnt_q <= '0; ref_pend_q <= 1'b0; ready_q <= 1'b0;
            held_q <= 1'b0; init_done_q <= 1'b0;
        end else begin
            st_q <= st_d; ras_n_q <= ras_n_d; cas_n_q <= cas_n_d; we_n_q <= we_n_d;
            cs_n_q <= cs_n_d; din_q <= din_d; a_q <= a_d; op_q <= op_d;
            row_q <= row_d; col_q <= col_d; rvalid_q <= rvalid_d; rdata_q <= rdata_d;
            init_q <= init_d; is_ref_q <= is_ref_d; ref_row_q <= ref_row_d;
            ref_cnt_q <= ref_cnt_d; ref_pend_q <= ref_pend_d; ready_q <= ready_d;
            held_q <= held_d; init_done_q <= init_done_d;
        end
    end

    // outputs straight from flip-flops
    assign o_ready     = ready_q;
    assign o_rvalid    = rvalid_q;
    assign o_rdata     = rdata_q;
    assign o_init_done = init_done_q;
    assign o_ras_n     = ras_n_q;
    assign o_cas_n     = cas_n_q;
    assign o_we_n      = we_n_q;
    assign o_cs_n      = cs_n_q;
    assign o_a         = a_q;
    assign o_din       = din_q;
endmodule // dmc_ctrl

// File: dv/dmc_dram_model.sv
/* behavioural 4096 x 1 dynamic memory seen at its pins, for the controller bench.
   assumes strobes from dmc_ctrl; a floating output shows the inverse of its last bit. */
module dmc_dram_model #(
    parameter int ACC_NS = 120                      // access from column fall, ns
) (
    input  wire logic                       i_ras_n, // row strobe
    input  wire logic                       i_cas_n, // column strobe
    input  wire logic                       i_we_n,  // write strobe
    input  wire logic                       i_cs_n,  // chip select
    input  wire logic [dmc_pkg::HALF_W-1:0] i_a,     // address pins
    input  wire logic                       i_din,   // data in
    output logic                            o_dout,  // data out
    output logic                            o_drive, // output active
    output int                              o_refs   // row strobes seen
);
    timeunit 1ns;
    timeprecision 1ps;
    import dmc_pkg::*;
    // =====================================================================
    // cell array and latches
    logic              mem_q [0:4095]; // cell array
    logic [HALF_W-1:0] row_q;          // latched row
    logic [HALF_W-1:0] col_q;          // latched column
    logic              sel_q = 1'b0;   // select latched with column
    logic              val_q = 1'b0;   // output latch
    // float never repeats the stale bit
    assign o_dout = o_drive ? val_q : ~val_q;
    initial begin
        foreach (mem_q[i]) mem_q[i] = 1'b0;
        o_drive = 1'b0;
        o_refs = 0;
    end
    // row latch; output untouched by row-only cycles
    always @(negedge i_ras_n) begin
        #1 row_q = i_a;
        o_refs = o_refs + 1;
    end
    // column latch, early write and output latch
    always @(negedge i_cas_n) begin
        o_drive = 1'b0;
        #1 if (!i_ras_n) begin
            col_q = i_a;
            sel_q = !i_cs_n;
            if (sel_q && !i_we_n) begin
                mem_q[{row_q, col_q}] = i_din;
                val_q <= #(ACC_NS) i_din;
                o_drive <= #(ACC_NS) 1'b1;
            end else if (sel_q) begin
                val_q <= #(ACC_NS) mem_q[{row_q, col_q}];
                o_drive <= #(ACC_NS) 1'b1;
            end
        end
    end
    // delayed write takes data at the write fall
    always @(negedge i_we_n) begin
        #1 if (!i_ras_n && !i_cas_n && sel_q) mem_q[{row_q, col_q}] = i_din;
    end
endmodule // dmc_dram_model

// File: dv/dmc_ctrl_sva.sv
/* concurrent checks on the controller's memory pins and on o_ready and o_init_done.
   bound into dmc_ctrl at the foot; sees the controller's ports only. */
module dmc_ctrl_sva (
    input wire logic                       i_clk,       // system clock
    input wire logic                       i_rstn,      // async reset, low
    input wire logic                       o_ready,     // request may be taken
    input wire logic                       o_init_done, // power-up done
    input wire logic                       o_ras_n,     // row strobe
    input wire logic                       o_cas_n,     // column strobe
    input wire logic                       o_we_n,      // write strobe
    input wire logic                       o_cs_n,      // chip select
    input wire logic [dmc_pkg::HALF_W-1:0] o_a,         // address pins
    input wire logic                       o_din        // write data
);
    timeunit 1ns;
    timeprecision 1ps;
    import dmc_pkg::*;
    localparam int GAP_MAX = REF_ROW_CYC + 100; // refresh due plus one cycle in flight
    logic             ras_q, ras_d;   // row strobe last cycle
    logic [CNT_W-1:0] gap_q, gap_d;   // cycles since row strobe fall
    logic [3:0]       refs_q, refs_d; // row strobes before init done
    // counters behind the refresh checks
    always_comb begin
        ras_d = o_ras_n;
        gap_d = (ras_q && !o_ras_n) ? '0 : gap_q + CNT_W'(gap_q != '1);
        refs_d = (ras_q && !o_ras_n && !o_init_done && refs_q != 4'hf) ? refs_q + 4'h1 : refs_q;
    end
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ras_q <= 1'b1;
            gap_q <= '0;
            refs_q <= '0;
        end else begin
            ras_q <= ras_d;
            gap_q <= gap_d;
            refs_q <= refs_d;
        end
    end
    // =====================================================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_row_fall; $fell(o_ras_n); endsequence
    sequence s_col_fall; $fell(o_cas_n); endsequence
    sequence s_din_held; $stable(o_din) ##1 $stable(o_din)[*6]; endsequence
    property p_row_hold; s_row_fall |=> $stable(o_a)[*3]; endproperty
    property p_col_setup; s_col_fall |-> $stable(o_a) && $stable(o_cs_n); endproperty
    property p_cas_in_row; s_col_fall |-> !o_ras_n; endproperty
    property p_early_din; s_col_fall and !o_we_n |-> s_din_held; endproperty
    property p_late_din; $fell(o_we_n) && !o_cas_n |-> s_din_held; endproperty
    property p_refresh_gap; gap_q <= GAP_MAX; endproperty
    property p_init_cas; !o_init_done |-> o_cas_n; endproperty
    property p_ready_init; o_ready |-> o_init_done; endproperty
    property p_init_refs; $rose(o_init_done) |-> refs_q >= 4'h8; endproperty
    a_row_hold: assert property (p_row_hold)
        else $error("row address moved during row hold");
    a_col_setup: assert property (p_col_setup)
        else $error("column address or select not set before column strobe");
    a_cas_in_row: assert property (p_cas_in_row)
        else $error("column strobe without row strobe");
    a_early_din: assert property (p_early_din)
        else $error("data in moved around early write edge");
    a_late_din: assert property (p_late_din)
        else $error("data in moved around delayed write edge");
    a_refresh_gap: assert property (p_refresh_gap)
        else $error("row refresh interval exceeded");
    a_init_cas: assert property (p_init_cas)
        else $error("column strobe during power-up refresh");
    a_ready_init: assert property (p_ready_init)
        else $error("ready before power-up refresh done");
    a_init_refs: assert property (p_init_refs)
        else $error("fewer than eight power-up refreshes");
endmodule // dmc_ctrl_sva
bind dmc_ctrl dmc_ctrl_sva chk_u (.i_clk(i_clk), .i_rstn(i_rstn), .o_ready(o_ready), .o_init_done(o_init_done),
    .o_ras_n(o_ras_n), .o_cas_n(o_cas_n), .o_we_n(o_we_n), .o_cs_n(o_cs_n), .o_a(o_a), .o_din(o_din));

// File: dv/tb_dmc_ctrl.sv
/* self-checking bench for dmc_ctrl driving a behavioural memory model.
   assumes the checker binds itself into dmc_ctrl. */
module tb_dmc_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import dmc_pkg::*;
    logic              i_clk, i_rstn, i_req, i_wdata, i_page, i_sel_n;
    logic [1:0]        i_op;
    logic [ADDR_W-1:0] i_addr;
    logic              o_ready, o_rvalid, o_rdata, o_init_done, ras_n, cas_n, we_n, cs_n, din, dout, m_drive;
    logic [HALF_W-1:0] a;
    int                m_refs, errors = 0, checks = 0;
    dmc_ctrl dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req), .i_op(i_op), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_page(i_page), .i_sel_n(i_sel_n), .i_dout(dout), .o_ready(o_ready),
        .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_init_done(o_init_done), .o_ras_n(ras_n),
        .o_cas_n(cas_n), .o_we_n(we_n), .o_cs_n(cs_n), .o_a(a), .o_din(din));
    dmc_dram_model #(.ACC_NS(120)) mem_u (.i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_cs_n(cs_n),
        .i_a(a), .i_din(din), .o_dout(dout), .o_drive(m_drive), .o_refs(m_refs));
    // =====================================================================
    // clock, compare, verdict
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one request held until taken, then followed until the controller is ready again
    task automatic op(input logic [1:0] k, input logic [ADDR_W-1:0] ad, input logic wd, sn, pg,
                      output logic got, output logic d);
        int n;
        got = 1'b0;
        d = 1'b0;
        n = 0;
        @(posedge i_clk);
        i_req <= 1'b1;
        i_op <= k;
        i_addr <= ad;
        i_wdata <= wd;
        i_sel_n <= sn;
        i_page <= pg;
        do @(posedge i_clk); while (o_ready !== 1'b1 && ++n < 6000);
        if (n >= 6000) errors++;                // request never taken
        i_req <= 1'b0;
        n = 0;
        do @(posedge i_clk); while (o_ready === 1'b1 && ++n < 4);
        n = 0;
        do begin
            @(posedge i_clk);
            if (o_rvalid === 1'b1) begin
                got = 1'b1;
                d = o_rdata;
            end
        end while (o_ready !== 1'b1 && ++n < 300);
        if (n >= 300) errors++;                 // cycle never finished
    endtask
    // power-up refreshes, then early writes read back
    task automatic t_init_write_read();
        logic g, d;
        int n;
        n = 0;
        while (o_ready !== 1'b1 && n < 3000) begin
            @(posedge i_clk);
            n++;
        end
        chk("init done", o_init_done, 1'b1);
        chk("power-up refreshes", m_refs >= 8, 1'b1);
        op(OP_WRITE, 12'h0c2, 1'b1, 1'b0, 1'b0, g, d);
        chk("early write out", {m_drive, dout}, 2'h3);
        op(OP_WRITE, 12'h083, 1'b0, 1'b0, 1'b0, g, d);
        chk("early write out", {m_drive, dout}, 2'h2);
        op(OP_READ, 12'h0c2, 1'b0, 1'b0, 1'b0, g, d);
        chk("read 0c2", {g, d}, 2'h3);
        op(OP_READ, 12'h083, 1'b0, 1'b0, 1'b0, g, d);
        chk("read 083", {g, d}, 2'h2);
    endtask
    // read-modify-write, deselected cycles
    task automatic t_rmw_desel();
        logic g, d;
        op(OP_RMW, 12'h0c2, 1'b0, 1'b0, 1'b0, g, d);
        chk("rmw old bit", {g, d}, 2'h3);
        op(OP_READ, 12'h0c2, 1'b0, 1'b0, 1'b0, g, d);
        chk("rmw new bit", {g, d}, 2'h2);
        op(OP_WRITE, 12'h083, 1'b1, 1'b1, 1'b0, g, d);
        chk("deselected float", m_drive, 1'b0);
        op(OP_READ, 12'h083, 1'b0, 1'b1, 1'b0, g, d);
        chk("deselected read", g, 1'b0);
        op(OP_READ, 12'h083, 1'b0, 1'b0, 1'b0, g, d);
        chk("write ignored", {g, d}, 2'h2);
    endtask
    // row-only refresh keeps output, page mode, periodic refresh
    task automatic t_refresh_page();
        logic g, d;
        int r;
        op(OP_WRITE, 12'h0c5, 1'b1, 1'b0, 1'b0, g, d);
        r = m_refs;
        op(OP_REFONLY, 12'h000, 1'b0, 1'b0, 1'b0, g, d);
        chk("row-only refresh", m_refs > r, 1'b1);
        chk("output kept", {m_drive, dout}, 2'h3);
        op(OP_READ, 12'h0c2, 1'b0, 1'b1, 1'b1, g, d);
        chk("page first deselected", g, 1'b0);
        op(OP_READ, 12'h0c5, 1'b0, 1'b0, 1'b1, g, d);
        chk("page read 0c5", {g, d}, 2'h3);
        op(OP_READ, 12'h0c2, 1'b0, 1'b0, 1'b0, g, d);
        chk("page read 0c2", {g, d}, 2'h2);
        r = m_refs;
        repeat (REF_ROW_CYC + 200) @(posedge i_clk);
        chk("periodic refresh", m_refs > r, 1'b1);
    endtask
    // main sequence
    initial begin
        i_rstn = 1'b0;
        i_req = 1'b0;
        i_op = OP_READ;
        i_addr = '0;
        i_wdata = 1'b0;
        i_page = 1'b0;
        i_sel_n = 1'b1;
        repeat (8) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_init_write_read();
        t_rmw_desel();
        t_refresh_page();
        complete_run();
    end
    // watchdog against a hang
    initial begin
        #(CLK_PERIOD_NS * 60000);
        errors++;
        complete_run();
    end
endmodule // tb_dmc_ctrl
